/* hw/port_bus_pin_ctrl.sv */
// top of port and bus pin control with apb register file
// ----------------------------------------------------------------------
// How it works
// R01: strap low after reset: single-chip/expansion; high: microprocessor.
// R02: everything stays in reset while presetn is low.
// R03: a low width strap gives a 16-bit external bus, a high one 8 bits.
// R04: the board holds the width strap fixed, tied low with no external bus.
// R05: port zero is 8 bits with a per-pin direction register.
// R06: in single-chip mode software sets input pull-ups per four-pin group.
// R07: outside single-chip mode bus pins get no pull-up, plain pins keep it.
// R08: a separate bus puts data bits 0-7 on port zero and 8-15 on port one.
// R09: ports one and two match port zero; port-one pins 5-7 can be irqs.
// R10: a pin serving as a bus bit is driven and sampled by bus logic only; the pin reads and the irqs on port-one pins 5-7 still sample it here.
// ----------------------------------------------------------------------
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module port_bus_pin_ctrl #(
    parameter int WIDTH = 8
) (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic mode_strap_pin, // processor mode strap
    input wire logic width_strap_pin, // bus width strap
    input wire logic [WIDTH-1:0] port_zero_in, // pad levels
    output logic [WIDTH-1:0] port_zero_out, // pad drive value
    output logic [WIDTH-1:0] port_zero_oe,  // pad drive enable
    output logic [WIDTH-1:0] port_zero_pu,  // pad pull-up
    input wire logic [WIDTH-1:0] port_one_in, // pad levels
    output logic [WIDTH-1:0] port_one_out, // pad drive value
    output logic [WIDTH-1:0] port_one_oe,  // pad drive enable
    output logic [WIDTH-1:0] port_one_pu,  // pad pull-up
    input wire logic [WIDTH-1:0] port_two_in, // pad levels
    output logic [WIDTH-1:0] port_two_out, // pad drive value
    output logic [WIDTH-1:0] port_two_oe,  // pad drive enable
    output logic [WIDTH-1:0] port_two_pu,  // pad pull-up
    output logic irq // interrupt, active high
);
    // ------------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] data_r [3];
    logic [WIDTH-1:0] dir_r [3];
    logic [WIDTH-1:0] pin_val [3];
    localparam int PG = pin_ctrl_pkg::PULL_GROUPS;
    logic [PG-1:0] pull_r;
    logic [7:0] ctrl_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [2:0] irq_prev_r;
    logic [15:0] bus_wdata_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic micro_strap;
    logic width8_strap;
    logic straps_valid;
    logic sep_bus;
    logic low_own;
    logic high_own;
    logic pull_allow;
    logic wr_en;
    logic rd_en;
    logic [2:0] irq_lvl;
    logic [2:0] irq_rise;
    logic [2:0] irq_sel;
    pin_ctrl_pkg::proc_mode_e mode;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;

    // ------------------------------------------------------------------
    // straps and processor mode
    // ------------------------------------------------------------------
    strap_capture u_straps (
        .pclk(pclk),
        .presetn(presetn), // see R02
        .mode_strap_pin(mode_strap_pin),
        .width_strap_pin(width_strap_pin),
        .micro_strap_r(micro_strap),
        .width8_strap_r(width8_strap),
        .straps_valid_r(straps_valid)
    );

    // mode: strap high forces microprocessor, else software picks expansion or single-chip
    always_comb begin
        if (micro_strap) begin
            mode = pin_ctrl_pkg::MODE_MICRO; // see R01
        end else if (ctrl_r[pin_ctrl_pkg::CTRL_EXPAND]) begin
            mode = pin_ctrl_pkg::MODE_EXPAND;
        end else begin
            mode = pin_ctrl_pkg::MODE_SINGLE;
        end
    end

    // bus ownership of port zero and port one
    assign sep_bus = straps_valid && (mode != pin_ctrl_pkg::MODE_SINGLE)
        && ctrl_r[pin_ctrl_pkg::CTRL_SEP_BUS];
    assign low_own = sep_bus; // see R08
    assign high_own = sep_bus && !width8_strap; // see R03
    assign pull_allow = 1'b1; // bus pins masked in slice, see R07

    // ------------------------------------------------------------------
    // the three ports
    // ------------------------------------------------------------------
    port_slice #(.WIDTH(WIDTH)) u_p0 (
        .pclk(pclk),
        .presetn(presetn),
        .dir(dir_r[0]), // see R05
        .dout(data_r[0]),
        .bus_own(low_own),
        .bus_drv(ctrl_r[pin_ctrl_pkg::CTRL_BUS_DRV]),
        .bus_dout(bus_wdata_r[7:0]),
        .pull_en(pull_r[1:0]),
        .pull_allow(pull_allow),
        .pin_in(port_zero_in),
        .pin_out_r(port_zero_out),
        .pin_oe_r(port_zero_oe),
        .pull_r(port_zero_pu),
        .pin_val_r(pin_val[0])
    );

    port_slice #(.WIDTH(WIDTH)) u_p1 (
        .pclk(pclk),
        .presetn(presetn),
        .dir(dir_r[1]), // see R09
        .dout(data_r[1]),
        .bus_own(high_own),
        .bus_drv(ctrl_r[pin_ctrl_pkg::CTRL_BUS_DRV]),
        .bus_dout(bus_wdata_r[15:8]),
        .pull_en(pull_r[3:2]),
        .pull_allow(pull_allow),
        .pin_in(port_one_in),
        .pin_out_r(port_one_out),
        .pin_oe_r(port_one_oe),
        .pull_r(port_one_pu),
        .pin_val_r(pin_val[1])
    );

    port_slice #(.WIDTH(WIDTH)) u_p2 (
        .pclk(pclk),
        .presetn(presetn),
        .dir(dir_r[2]), // see R09
        .dout(data_r[2]),
        .bus_own(1'b0),
        .bus_drv(1'b0),
        .bus_dout('0),
        .pull_en(pull_r[5:4]),
        .pull_allow(pull_allow),
        .pin_in(port_two_in),
        .pin_out_r(port_two_out),
        .pin_oe_r(port_two_oe),
        .pull_r(port_two_pu),
        .pin_val_r(pin_val[2])
    );

    // ------------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------------
    assign wr_en = psel && penable && pwrite && pready_r;
    assign rd_en = psel && penable && !pwrite && !pready_r;

    // known address check, used by the error flag only
    function automatic logic addr_known(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= pin_ctrl_pkg::OFF_BUS_RDATA);
    endfunction

    // one wait state: ready is low in the first access cycle, high in the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !addr_known(paddr);
        end
    end

    // port data and direction registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                data_r[i] <= '0;
                dir_r[i] <= '0;
            end
        end else if (wr_en) begin
            for (int i = 0; i < 3; i++) begin
                if (paddr == 8'(pin_ctrl_pkg::OFF_DATA0 + 8'(8 * i))) begin
                    data_r[i] <= pwdata[WIDTH-1:0];
                end
                if (paddr == 8'(pin_ctrl_pkg::OFF_DIR0 + 8'(8 * i))) begin
                    dir_r[i] <= pwdata[WIDTH-1:0]; // see R05
                end
            end
        end
    end

    // pull-up groups, control and bus write data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_r <= '0;
            ctrl_r <= '0;
            bus_wdata_r <= '0;
        end else if (wr_en) begin
            if (paddr == pin_ctrl_pkg::OFF_PULL) begin
                pull_r <= pwdata[PG-1:0]; // see R06
            end
            if (paddr == pin_ctrl_pkg::OFF_CTRL) begin
                ctrl_r <= pwdata[7:0];
            end
            if (paddr == pin_ctrl_pkg::OFF_BUS_WDATA) begin
                bus_wdata_r <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // external interrupt inputs on port one top pins
    // ------------------------------------------------------------------
    assign irq_sel = ctrl_r[pin_ctrl_pkg::CTRL_IRQ_SEL +: 3];
    assign irq_lvl = pin_val[1][pin_ctrl_pkg::IRQ_PIN_LO +: 3] & irq_sel
        & ~dir_r[1][7:5];
    assign irq_rise = irq_lvl & ~irq_prev_r; // see R09

    // raw pin level, so selecting a pin already high is no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev_r <= '0;
        end else begin
            irq_prev_r <= pin_val[1][pin_ctrl_pkg::IRQ_PIN_LO +: 3];
        end
    end

    // sticky status, write one clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr_en && paddr == pin_ctrl_pkg::OFF_IRQ_MASK) begin
                irq_mask_r <= pwdata[2:0];
            end
            if (wr_en && paddr == pin_ctrl_pkg::OFF_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | irq_rise;
            end else begin
                irq_stat_r <= irq_stat_r | irq_rise;
            end
        end
    end

    // interrupt output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= pin_ctrl_pkg::RST_ZERO;
        end else if (rd_en) begin
            case (paddr)
                pin_ctrl_pkg::OFF_DATA0: prdata_r <= 32'(data_r[0]);
                pin_ctrl_pkg::OFF_DIR0: prdata_r <= 32'(dir_r[0]);
                pin_ctrl_pkg::OFF_DATA1: prdata_r <= 32'(data_r[1]);
                pin_ctrl_pkg::OFF_DIR1: prdata_r <= 32'(dir_r[1]);
                pin_ctrl_pkg::OFF_DATA2: prdata_r <= 32'(data_r[2]);
                pin_ctrl_pkg::OFF_DIR2: prdata_r <= 32'(dir_r[2]);
                pin_ctrl_pkg::OFF_PIN0: prdata_r <= 32'(pin_val[0]);
                pin_ctrl_pkg::OFF_PIN1: prdata_r <= 32'(pin_val[1]);
                pin_ctrl_pkg::OFF_PIN2: prdata_r <= 32'(pin_val[2]);
                pin_ctrl_pkg::OFF_PULL: prdata_r <= 32'(pull_r);
                pin_ctrl_pkg::OFF_CTRL: prdata_r <= 32'(ctrl_r);
                pin_ctrl_pkg::OFF_STAT: prdata_r <= 32'({width8_strap,
                    2'(mode)});
                pin_ctrl_pkg::OFF_IRQ_STAT: prdata_r <= 32'(irq_stat_r);
                pin_ctrl_pkg::OFF_IRQ_MASK: prdata_r <= 32'(irq_mask_r);
                pin_ctrl_pkg::OFF_BUS_WDATA: prdata_r <= 32'(bus_wdata_r);
                pin_ctrl_pkg::OFF_BUS_RDATA: prdata_r <= 32'({pin_val[1],
                    pin_val[0]}); // see R10
                default: prdata_r <= pin_ctrl_pkg::RST_ZERO;
            endcase
        end
    end
endmodule // port_bus_pin_ctrl

/* include/pin_ctrl_pkg.sv */
// package with register map, field positions and reset values of the pin block
package pin_ctrl_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_DATA0 = 8'h00;
    localparam logic [7:0] OFF_DIR0 = 8'h04;
    localparam logic [7:0] OFF_DATA1 = 8'h08;
    localparam logic [7:0] OFF_DIR1 = 8'h0c;
    localparam logic [7:0] OFF_DATA2 = 8'h10;
    localparam logic [7:0] OFF_DIR2 = 8'h14;
    localparam logic [7:0] OFF_PIN0 = 8'h18;
    localparam logic [7:0] OFF_PIN1 = 8'h1c;
    localparam logic [7:0] OFF_PIN2 = 8'h20;
    localparam logic [7:0] OFF_PULL = 8'h24;
    localparam logic [7:0] OFF_CTRL = 8'h28;
    localparam logic [7:0] OFF_STAT = 8'h2c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
    localparam logic [7:0] OFF_BUS_WDATA = 8'h38;
    localparam logic [7:0] OFF_BUS_RDATA = 8'h3c;
    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_SEP_BUS = 0;   // separate data bus enabled
    localparam int CTRL_EXPAND = 1;    // memory expansion requested
    localparam int CTRL_BUS_DRV = 2;   // bus drives pins (write cycle)
    localparam int CTRL_IRQ_SEL = 4;   // 3 bits: irq select per pin
    localparam int STAT_MODE = 0;      // 2 bits processor mode
    localparam int STAT_WIDTH8 = 2;    // 1 = 8-bit bus
    localparam int IRQ_PIN_LO = 5;     // lowest irq capable pin of port one
    localparam int NUM_IRQ = 3;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam int PULL_GROUPS = 6;    // 3 ports x 2 nibbles
    localparam int RESET_HOLD_CYCLES = 2; // strap sample delay after release
    // processor modes
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_EXPAND,
        MODE_MICRO
    } proc_mode_e;
endpackage

/* hw/strap_capture.sv */
// strap sampler: catches mode and width straps after reset release
`timescale 1ns/1ps
module strap_capture (
    input wire logic pclk,            // clock
    input wire logic presetn,         // async reset, active low
    input wire logic mode_strap_pin,  // processor mode strap
    input wire logic width_strap_pin, // bus width strap
    output logic micro_strap_r,       // high = microprocessor mode
    output logic width8_strap_r,      // high = 8-bit bus
    output logic straps_valid_r       // straps captured
);
    logic [1:0] hold_cnt_r;

    // count a few edges after release, then latch straps once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_r <= 2'h0;
            micro_strap_r <= 1'b0;
            width8_strap_r <= 1'b0;
            straps_valid_r <= 1'b0;
        end else if (!straps_valid_r) begin
            if (hold_cnt_r == 2'(pin_ctrl_pkg::RESET_HOLD_CYCLES)) begin
                micro_strap_r <= mode_strap_pin; // see R01
                width8_strap_r <= width_strap_pin; // see R03
                straps_valid_r <= 1'b1;
            end else begin
                hold_cnt_r <= hold_cnt_r + 2'h1;
            end
        end
    end
endmodule // strap_capture

/* hw/port_slice.sv */
// one 8-bit port: direction, output data, bus override and pull-ups
`timescale 1ns/1ps
module port_slice #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,              // clock
    input wire logic presetn,           // async reset, active low
    input wire logic [WIDTH-1:0] dir,   // 1 = output
    input wire logic [WIDTH-1:0] dout,  // port output data
    input wire logic bus_own,           // bus controller owns the pins
    input wire logic bus_drv,           // bus drives pins
    input wire logic [WIDTH-1:0] bus_dout, // bus write data
    input wire logic [1:0] pull_en,     // pull-up per nibble
    input wire logic pull_allow,        // pull-ups allowed for this port
    input wire logic [WIDTH-1:0] pin_in, // pad input
    output logic [WIDTH-1:0] pin_out_r, // pad output value
    output logic [WIDTH-1:0] pin_oe_r,  // pad output enable
    output logic [WIDTH-1:0] pull_r,    // pad pull-up enable
    output logic [WIDTH-1:0] pin_val_r  // sampled pad level
);
    // pad drive: bus overrides port registers while it owns the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end else if (bus_own) begin
            pin_out_r <= bus_dout; // see R10
            pin_oe_r <= {WIDTH{bus_drv}}; // see R08
        end else begin
            pin_out_r <= dout;
            pin_oe_r <= dir; // see R05
        end
    end

    // pull-ups only on input pins, per nibble, never on bus pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_r <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                pull_r[i] <= pull_en[i/4] & ~dir[i] & ~bus_own
                    & pull_allow; // see R06 see R07
            end
        end
    end

    // sample pad levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_val_r <= '0;
        end else begin
            pin_val_r <= pin_in;
        end
    end
endmodule // port_slice

/* sim/port_bus_pin_ctrl_assertions.sv */
// checker of apb timing and pad relations at the pin control top
`timescale 1ns/1ps
module port_bus_pin_ctrl_assertions #(
    parameter int WIDTH = 8
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [WIDTH-1:0] port_zero_oe, // drive enables
    input wire logic [WIDTH-1:0] port_one_oe, // drive enables
    input wire logic [WIDTH-1:0] port_two_oe, // drive enables
    input wire logic [WIDTH-1:0] port_zero_pu, // pull-ups
    input wire logic [WIDTH-1:0] port_one_pu, // pull-ups
    input wire logic [WIDTH-1:0] port_two_pu // pull-ups
);
    logic [3:0] wr_hist_r;
    logic acc_wr;
    logic bad_addr;
    logic nib_ok;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // nibble is all pulled or all unpulled on its input pins
    function automatic logic nib(input logic [3:0] pu, input logic [3:0] oe);
        return ((pu & ~oe) == 4'h0) || ((pu | oe) == 4'hf);
    endfunction
    // taken write and illegal address decode
    assign acc_wr = psel & penable & pready & pwrite;
    assign bad_addr = (paddr > 8'h3c) | (paddr[1:0] != 2'b00);
    assign nib_ok = nib(port_zero_pu[3:0], port_zero_oe[3:0])
        & nib(port_zero_pu[7:4], port_zero_oe[7:4])
        & nib(port_one_pu[3:0], port_one_oe[3:0])
        & nib(port_one_pu[7:4], port_one_oe[7:4])
        & nib(port_two_pu[3:0], port_two_oe[3:0])
        & nib(port_two_pu[7:4], port_two_oe[7:4]);
    // history of taken writes, pads may only move after one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_hist_r <= 4'h0;
        end else begin
            wr_hist_r <= {wr_hist_r[2:0], acc_wr};
        end
    end
    AST_READY_LATENCY: assert property (
        psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready late");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("lone pslverr");
    AST_ERR_DECODE: assert property (
        psel && penable && pready |-> pslverr == bad_addr)
        else $error("pslverr wrong");
    AST_RESET_QUIET: assert property ($rose(presetn) |->
        (port_zero_oe | port_one_oe | port_two_oe) == '0 && !pready)
        else $error("active after reset");
    AST_PU_INPUT_ONLY: assert property (
        ((port_zero_pu & port_zero_oe) | (port_one_pu & port_one_oe)
        | (port_two_pu & port_two_oe)) == '0)
        else $error("pull-up on output");
    AST_PU_NIBBLE: assert property (nib_ok)
        else $error("pull-up group split");
    AST_OE_CAUSE: assert property (!$stable(port_zero_oe)
        || !$stable(port_one_oe) || !$stable(port_two_oe) |-> wr_hist_r != 0)
        else $error("drive enable moved unasked");
endmodule // port_bus_pin_ctrl_assertions

bind port_bus_pin_ctrl port_bus_pin_ctrl_assertions #(.WIDTH(WIDTH)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .port_zero_oe(port_zero_oe), .port_one_oe(port_one_oe),
    .port_two_oe(port_two_oe), .port_zero_pu(port_zero_pu),
    .port_one_pu(port_one_pu), .port_two_pu(port_two_pu)
);

/* sim/bus_mem_model.sv */
// external memory and board on the data bus pins of ports zero and one
`timescale 1ns/1ps
module bus_mem_model (
    input wire logic pclk,            // clock
    input wire logic [15:0] bus_out,  // device drive values
    input wire logic [15:0] bus_oe,   // device drive enables
    input wire logic [15:0] bus_pu,   // device pull-ups
    input wire logic drive_en,        // memory returns read data
    input wire logic [15:0] rd_word,  // read data of the memory
    output logic [15:0] pin_lvl,      // resolved pad levels
    output logic [15:0] last_wr       // last full word written
);
    logic [15:0] prev_r = 16'h0000;
    // wire level: device, then memory, then pull-up, else wandering
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pin_lvl[i] = bus_oe[i] ? bus_out[i] :
                drive_en ? rd_word[i] : bus_pu[i] ? 1'b1 : ~prev_r[i];
        end
    end
    // floating lines toggle each cycle, full-width writes are stored
    always_ff @(posedge pclk) begin
        prev_r <= pin_lvl;
        if (&bus_oe) begin
            last_wr <= bus_out;
        end
    end
endmodule // bus_mem_model

/* sim/test_port_bus_pin_ctrl.sv */
// self-checking testbench of the port and bus pin control
`timescale 1ns/1ps
module test_port_bus_pin_ctrl;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, mode_s = 1'b0, width_s = 1'b0, drv = 1'b0;
    logic pready, pslverr, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] rd_word = 16'h0000, last_wr, lvl;
    logic [7:0] out_a [3], oe_a [3], pu_a [3], p2_in;
    int fails = 0, tests_run = 0, cyc = 0;
    // clock, cycle ceiling and port two board level
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            give_verdict();
        end
    end
    assign p2_in = (oe_a[2] & out_a[2]) | (~oe_a[2] & 8'h96);
    port_bus_pin_ctrl dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_strap_pin(mode_s), .width_strap_pin(width_s),
        .port_zero_in(lvl[7:0]), .port_zero_out(out_a[0]),
        .port_zero_oe(oe_a[0]), .port_zero_pu(pu_a[0]),
        .port_one_in(lvl[15:8]), .port_one_out(out_a[1]),
        .port_one_oe(oe_a[1]), .port_one_pu(pu_a[1]), .port_two_in(p2_in),
        .port_two_out(out_a[2]), .port_two_oe(oe_a[2]),
        .port_two_pu(pu_a[2]), .irq(irq));
    bus_mem_model mem (.pclk(pclk), .bus_out({out_a[1], out_a[0]}),
        .bus_oe({oe_a[1], oe_a[0]}), .bus_pu({pu_a[1], pu_a[0]}),
        .drive_en(drv), .rd_word(rd_word), .pin_lvl(lvl), .last_wr(last_wr));
    // compare, bus cycle and reset helpers
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        chk("apb wait", 32'h1, 32'(n));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(string nm, logic [7:0] a, logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, x, r);
    endtask
    task automatic do_reset(input logic m, input logic w);
        presetn <= 1'b0;
        mode_s <= m;
        width_s <= w;
        repeat (5) @(posedge pclk);
        chk("reset", 32'h0, {oe_a[0], oe_a[1], pu_a[2], 8'(irq)});
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    // scenarios
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        for (int a = 0; a <= 'h34; a += 4) begin
            if (a < 'h18 || a > 'h20) rdchk("reg", 8'(a), 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("unmapped read", 32'h1, {r[30:0], e});
        apb(1'b1, 8'h06, 32'hff, r, e);
        chk("misaligned err", 32'h1, 32'(e));
        rdchk("dir0 kept", 8'h04, 32'h0);
    endtask
    task automatic t_port_dir;
        logic [7:0] ext;
        drv <= 1'b1;
        rd_word <= 16'h5a69;
        for (int i = 0; i < 3; i++) begin
            ext = (i == 0) ? 8'h69 : (i == 1) ? 8'h5a : 8'h96;
            wr(8'(8 * i), 32'h3c);
            wr(8'(8 * i + 4), 32'ha5);
            repeat (3) @(posedge pclk);
            chk("port oe", 32'ha5, {24'h0, oe_a[i]});
            chk("port out", 32'h24, {24'h0, out_a[i] & 8'ha5});
            rdchk("pin level", 8'(24 + 4 * i),
                {24'h0, 8'h24 | (ext & 8'h5a)});
        end
    endtask
    task automatic t_pull;
        wr(8'h04, 32'h0f);
        wr(8'h24, 32'h3e);
        repeat (3) @(posedge pclk);
        chk("pull", 32'hf05a5a, {pu_a[0], pu_a[1], pu_a[2]});
        wr(8'h24, 32'h01);
        repeat (3) @(posedge pclk);
        chk("pull group", 32'h0, {pu_a[0], pu_a[1], pu_a[2]});
    endtask
    task automatic t_bus;
        wr(8'h24, 32'h3f);
        wr(8'h28, 32'h3);
        repeat (3) @(posedge pclk);
        rdchk("expansion mode", 8'h2c, 32'h1);
        chk("pads", 32'h5a, {oe_a[0], oe_a[1], pu_a[0], pu_a[2]});
        rdchk("bus read", 8'h3c, 32'h5a69);
        drv <= 1'b0;
        wr(8'h38, 32'hc3e1);
        wr(8'h28, 32'h7);
        repeat (3) @(posedge pclk);
        chk("bus write oe", 32'hffff, {oe_a[1], oe_a[0]});
        chk("bus write out", 32'hc3e1, {out_a[1], out_a[0]});
        chk("memory got", 32'hc3e1, {16'h0, last_wr});
        wr(8'h28, 32'h0);
    endtask
    task automatic t_irq;
        wr(8'h0c, 32'h0);
        drv <= 1'b1;
        rd_word <= 16'h0000;
        wr(8'h28, 32'h10);
        rd_word <= 16'he000;
        repeat (4) @(posedge pclk);
        rdchk("irq one pin", 8'h30, 32'h1);
        chk("irq masked", 32'h0, 32'(irq));
        wr(8'h34, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq raised", 32'h1, 32'(irq));
        wr(8'h30, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq cleared", 32'h0, 32'(irq));
        wr(8'h28, 32'h70);
        rd_word <= 16'h0000;
        repeat (3) @(posedge pclk);
        rd_word <= 16'he000;
        repeat (4) @(posedge pclk);
        rdchk("irq three pins", 8'h30, 32'h7);
        wr(8'h30, 32'h7);
    endtask
    task automatic t_micro;
        drv <= 1'b0;
        do_reset(1'b1, 1'b1);
        rdchk("micro width8", 8'h2c, 32'h6);
        wr(8'h24, 32'h0f);
        wr(8'h28, 32'h1);
        repeat (3) @(posedge pclk);
        chk("narrow bus pulls", 32'h00ff, {pu_a[0], pu_a[1]});
    endtask
    // closing report
    task automatic give_verdict;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        do_reset(1'b0, 1'b0);
        t_regs();
        t_port_dir();
        t_pull();
        t_bus();
        t_irq();
        t_micro();
        give_verdict();
    end
endmodule // test_port_bus_pin_ctrl
